// >>> hdl/ocpu_map.vh
// Register offsets, field positions and reset values of the compare/PWM channel
// Assumes a 32-bit Avalon-MM slave with word addresses counted in bytes
`ifndef OCPU_MAP_VH
`define OCPU_MAP_VH
`define OCPU_ADDR_CTRL1      4'h0
`define OCPU_ADDR_CTRL2      4'h4
`define OCPU_ADDR_PRIMARY    4'h8
`define OCPU_ADDR_SECONDARY  4'hC
`define OCPU_CTRL1_RESET     16'h0000
`define OCPU_CTRL2_RESET     16'h000C
`define OCPU_CTRL1_MASK      16'h3C9F
`define OCPU_CTRL2_MASK      16'hF1FF
`define OCPU_MODE_LSB        0
`define OCPU_TRIGGER_CLEAR_MODE_BIT_BIT    3
`define OCPU_FLTSTAT_BIT     4
`define OCPU_FLTEN_BIT       7
`define OCPU_TBSEL_LSB       10
`define OCPU_IDLE_BIT        13
`define OCPU_SYNC_LSB        0
`define OCPU_TRIS_BIT        5
`define OCPU_TRIGGER_STATUS_BIT_BIT    6
`define OCPU_TRIGSEL_BIT     7
`define OCPU_CASCADE_BIT     8
`define OCPU_INVERT_BIT      12
`define OCPU_FLTTRI_BIT      13
`define OCPU_FAULT_OUTPUT_LEVEL_BIT_BIT      14
`define OCPU_FAULT_MODE_BIT_BIT       15
`define OCPU_MODE_OFF        3'h0
`define OCPU_MODE_SC_SHOT_LO 3'h1
`define OCPU_MODE_SC_SHOT_HI 3'h2
`define OCPU_MODE_SC_TOGGLE  3'h3
`define OCPU_MODE_DC_SHOT    3'h4
`define OCPU_MODE_DC_CONT    3'h5
`define OCPU_MODE_PWM_EDGE   3'h6
`define OCPU_MODE_PWM_CENTER 3'h7
`define OCPU_SYNC_NONE       5'h00
`define OCPU_SYNC_SELF       5'h1F
`define OCPU_TB_SYSCLK       3'h7
`endif

// >>> hdl/ocpu_channel.v
// Output compare / PWM channel with dedicated 16-bit counter and Avalon-MM registers
// Assumes fault pins and the idle request are asynchronous; timer ticks and source events come from this clock domain
//
// Functional notes
// [R01] Duty values may be written any time; they latch when count equals period.
// [R02] PWM period lasts period value plus one time-base counts; center-aligned mode counts up and down, taking twice that.
// [R03] Duty and period all zero keeps output low.
// [R04] Secondary value above period keeps output high.
// [R05] Double buffering only in PWM modes; buffers hidden from software.
// [R06] PWM supports edge-aligned and center-aligned waveforms.
// [R07] Three-bit mode field in control 1 bits 2:0 picks the operating mode.
// [R08] Double compare starts low, toggles on primary/secondary matches; single-shot once.
// [R09] Software selects self as sync source and clears trigger select for PWM.
// [R10] Three-bit time base field at control 1 bits 12:10 selects clock tick.
// [R11] Software starts the selected timer before the time base runs.
// [R12] Fault mode bit set: fault holds until source gone and status cleared.
// [R13] Fault drives output to fault level, or tri-states when enabled.
// [R14] Fault pin A serves channels 1-4, pin B channels 5-9, gated by enable.
// [R15] Software enables the compare interrupt when using fault pins.
// [R16] Cascade bit joins this channel with its partner as 32-bit channel.
// [R17] Trigger status set by trigger event; counter held clear while it is clear.
// [R18] Pin direction bit set tri-states the output pin.
// [R19] Five-bit sync field: zero free-run, all ones self, 1000x reserved.
// [R20] Capture, comparator, converter and charge unit are trigger-only sources.
// [R21] Software never makes a channel its own trigger source.
// [R22] Free-running counter counts up and wraps from maximum to zero.
// [R23] Trigger select set waits for event; clear resets counter on each event.
// [R24] Cascaded: odd channel holds low half, its wraps advance even channel.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "ocpu_map.vh"
module ocpu_channel #(
  parameter CHANNEL_NUMBER = 1,
  parameter WIDTH          = 16
) (
  // Clock and reset
  input  wire              clk,
  input  wire              nrst,
  input  wire              clk_en,
  // Avalon-MM slave
  input  wire [3:0]        address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output reg  [31:0]       readdata,
  output wire              waitrequest,
  // Time base ticks, one per timer count, from timers 1 to 5
  input  wire [4:0]        timer_tick,
  // Sync/trigger source events, indexed by sync source code
  input  wire [31:0]       source_event,
  // Cascade link with adjacent channel
  input  wire              cascade_carry_in,
  output wire              cascade_carry_out,
  // Fault pins and idle request
  input  wire              fault_pin_a,
  input  wire              fault_pin_b,
  input  wire              cpu_idle,
  // Output pin and status
  output reg               compare_output_pin,
  output wire              compare_output_oe,
  output reg               compare_interrupt_flag,
  output reg  [WIDTH-1:0]  internal_channel_counter
);

  reg  [15:0]      ctrl1;
  reg  [15:0]      ctrl2;
  reg  [WIDTH-1:0] primary_compare_value;
  reg  [WIDTH-1:0] secondary_compare_value;
  reg  [WIDTH-1:0] primary_active;
  reg  [WIDTH-1:0] secondary_active;
  reg              pin_level;
  reg              shot_done;
  reg              count_down;
  reg              fault_active;
  reg  [1:0]       fa_sync;
  reg  [1:0]       fb_sync;
  reg  [1:0]       idle_sync;
  reg              rd_pending;

  wire [2:0]       mode      = ctrl1[`OCPU_MODE_LSB+2:`OCPU_MODE_LSB];
  wire [2:0]       tb_sel    = ctrl1[`OCPU_TBSEL_LSB+2:`OCPU_TBSEL_LSB];
  wire [4:0]       sync_sel  = ctrl2[`OCPU_SYNC_LSB+4:`OCPU_SYNC_LSB];
  wire             is_pwm    = mode[2] & mode[1];
  wire             trig_mode = ctrl2[`OCPU_TRIGSEL_BIT];
  wire             cascade   = ctrl2[`OCPU_CASCADE_BIT];
  wire             even_chan = (CHANNEL_NUMBER % 2) == 0;

  // Period match uses the primary value in every mode, both for non-PWM self-sync and for PWM
  wire [WIDTH-1:0] timer_period_value = primary_active;

  // Avalon-MM: writes complete at once, reads take one wait cycle
  assign waitrequest = read & ~rd_pending;

  // Merge byte lanes into a register and drop unimplemented bits
  function [15:0] ocpu_merge;
    input [15:0] old_val;
    input [31:0] data;
    input [3:0]  be;
    input [15:0] mask;
    begin
      ocpu_merge[7:0]  = be[0] ? data[7:0] : old_val[7:0];
      ocpu_merge[15:8] = be[1] ? data[15:8] : old_val[15:8];
      ocpu_merge       = ocpu_merge & mask;
    end
  endfunction

  // Time base tick selection
  reg tick;
  always @* begin
    case (tb_sel)
      3'h0:            tick = timer_tick[1]; // see [R10]
      3'h1:            tick = timer_tick[2];
      3'h2:            tick = timer_tick[3];
      3'h3:            tick = timer_tick[0];
      3'h4:            tick = timer_tick[4];
      `OCPU_TB_SYSCLK: tick = 1'b1;
      // Codes 5 and 6 are reserved and stop the time base
      default:         tick = 1'b0;
    endcase
  end

  // Sync source decode; reserved codes and none give no event
  wire reserved_src = (sync_sel[4:1] == 4'h8);
  wire src_event    = (sync_sel != `OCPU_SYNC_NONE) && !reserved_src && source_event[sync_sel]; // see [R19]
  wire syncing      = (sync_sel != `OCPU_SYNC_NONE) && !reserved_src;

  // Count advance: cascaded even channel counts only on partner wraps
  wire advance      = cascade && even_chan ? cascade_carry_in : tick; // see [R16] [R24]
  // Trigger mode holds the counter until the trigger status bit is set
  wire running      = !trig_mode || ctrl2[`OCPU_TRIGGER_STATUS_BIT_BIT];
  wire period_match = (internal_channel_counter == timer_period_value);
  wire self_reset   = (sync_sel == `OCPU_SYNC_SELF) && period_match;
  assign cascade_carry_out = cascade && !even_chan && advance && running &&
                             (internal_channel_counter == {WIDTH{1'b1}}); // see [R24]

  // Fault input picked by channel number, gated by the enable bit
  wire fault_in = ctrl1[`OCPU_FLTEN_BIT] &&
                  ((CHANNEL_NUMBER <= 4) ? fa_sync[1] : fb_sync[1]); // see [R14]
  // Idle request freezes counter and waveform when the idle bit is set
  wire frozen   = ctrl1[`OCPU_IDLE_BIT] && idle_sync[1];
  // One period end per PWM cycle; center-aligned counts it on the way up
  wire cycle_end = advance && period_match && !count_down;

  // Output pin driver
  wire out_level = fault_active ? ctrl2[`OCPU_FAULT_OUTPUT_LEVEL_BIT_BIT] : pin_level; // see [R13]
  assign compare_output_oe = !ctrl2[`OCPU_TRIS_BIT] &&
                             !(fault_active && ctrl2[`OCPU_FLTTRI_BIT]); // see [R18] [R13]

  // Two-stage synchronisers for pins from outside this clock domain
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fa_sync   <= 2'h0;
      fb_sync   <= 2'h0;
      idle_sync <= 2'h0;
    end else if (clk_en) begin
      fa_sync   <= {fa_sync[0], fault_pin_a};
      fb_sync   <= {fb_sync[0], fault_pin_b};
      idle_sync <= {idle_sync[0], cpu_idle};
    end
  end

  // Register file and bus read
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1                   <= `OCPU_CTRL1_RESET;
      ctrl2                   <= `OCPU_CTRL2_RESET;
      primary_compare_value   <= {WIDTH{1'b0}};
      secondary_compare_value <= {WIDTH{1'b0}};
      readdata                <= 32'h0000_0000;
      rd_pending              <= 1'b0;
    end else if (clk_en) begin
      rd_pending <= read & ~rd_pending;
      if (read && !rd_pending) begin
        case (address)
          `OCPU_ADDR_CTRL1:     readdata <= {16'h0000, ctrl1};
          `OCPU_ADDR_CTRL2:     readdata <= {16'h0000, ctrl2};
          `OCPU_ADDR_PRIMARY:   readdata <= {{(32-WIDTH){1'b0}}, primary_compare_value};
          `OCPU_ADDR_SECONDARY: readdata <= {{(32-WIDTH){1'b0}}, secondary_compare_value};
          default:              readdata <= 32'h0000_0000;
        endcase
      end
      // Software writes, masked to the implemented bits
      if (write) begin
        case (address)
          `OCPU_ADDR_CTRL1:     ctrl1 <= ocpu_merge(ctrl1, writedata, byteenable, `OCPU_CTRL1_MASK); // see [R07]
          `OCPU_ADDR_CTRL2:     ctrl2 <= ocpu_merge(ctrl2, writedata, byteenable, `OCPU_CTRL2_MASK);
          `OCPU_ADDR_PRIMARY:   primary_compare_value <= ocpu_merge(primary_compare_value, writedata,
                                                                    byteenable, 16'hFFFF); // see [R01]
          `OCPU_ADDR_SECONDARY: secondary_compare_value <= ocpu_merge(secondary_compare_value, writedata,
                                                                      byteenable, 16'hFFFF);
          default:              ;
        endcase
      end
      // Hardware set of fault status wins over software clear
      if (fault_in && is_pwm)
        ctrl1[`OCPU_FLTSTAT_BIT] <= 1'b1;
      else if (!fault_in && !ctrl2[`OCPU_FAULT_MODE_BIT_BIT] && cycle_end && !frozen)
        ctrl1[`OCPU_FLTSTAT_BIT] <= 1'b0; // see [R12]
      // Trigger status: event sets, wins over clear
      if (trig_mode && src_event)
        ctrl2[`OCPU_TRIGGER_STATUS_BIT_BIT] <= 1'b1; // see [R17]
      else if (ctrl1[`OCPU_TRIGGER_CLEAR_MODE_BIT_BIT] && advance && !frozen &&
               internal_channel_counter == secondary_active && running)
        ctrl2[`OCPU_TRIGGER_STATUS_BIT_BIT] <= 1'b0;
    end
  end

  // Counter, active compare values and waveform
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_channel_counter <= {WIDTH{1'b0}};
      primary_active           <= {WIDTH{1'b0}};
      secondary_active         <= {WIDTH{1'b0}};
      pin_level                <= 1'b0;
      shot_done                <= 1'b0;
      count_down               <= 1'b0;
      compare_interrupt_flag   <= 1'b0;
      compare_output_pin       <= 1'b0;
    end else if (clk_en && !frozen) begin
      compare_interrupt_flag <= 1'b0;
      compare_output_pin     <= out_level ^ ctrl2[`OCPU_INVERT_BIT];
      if (!is_pwm) begin
        primary_active   <= primary_compare_value; // see [R05]
        secondary_active <= secondary_compare_value;
      end
      if (write && address == `OCPU_ADDR_CTRL1) begin
        shot_done <= 1'b0;
        pin_level <= 1'b0; // see [R08]
      end
      if (mode == `OCPU_MODE_OFF || (trig_mode && !running)) begin
        internal_channel_counter <= {WIDTH{1'b0}}; // see [R17]
        count_down               <= 1'b0;
        if (mode == `OCPU_MODE_OFF)
          pin_level <= 1'b0;
      end else if (!trig_mode && src_event && sync_sel != `OCPU_SYNC_SELF) begin
        internal_channel_counter <= {WIDTH{1'b0}}; // see [R23]
      end else if (advance) begin
        if (mode == `OCPU_MODE_PWM_CENTER) begin
          // Up to period then down to zero
          if (!count_down && period_match)
            count_down <= 1'b1; // see [R06]
          else if (count_down && internal_channel_counter == {WIDTH{1'b0}})
            count_down <= 1'b0;
          else
            internal_channel_counter <= count_down ? internal_channel_counter - 1'b1
                                                   : internal_channel_counter + 1'b1;
        end else begin
          // Direction flag only matters in center-aligned mode; clear it so a mode change cannot block period ends
          count_down <= 1'b0;
          if (self_reset || (is_pwm && period_match))
            internal_channel_counter <= {WIDTH{1'b0}}; // see [R02]
          else
            internal_channel_counter <= internal_channel_counter + 1'b1; // see [R22]
        end
        // PWM: reload duty at period end, drop the pin at the duty match
        if (is_pwm) begin
          if (cycle_end) begin
            primary_active   <= primary_compare_value; // see [R01] [R05]
            secondary_active <= secondary_compare_value;
            pin_level        <= (secondary_compare_value != {WIDTH{1'b0}}); // see [R03]
            compare_interrupt_flag <= 1'b1;
          end else if (internal_channel_counter == secondary_active &&
                       secondary_active <= timer_period_value) begin
            pin_level <= 1'b0; // see [R04]
          end
        end else if (!shot_done) begin
          // Compare modes: primary match lowers, raises or toggles per single-compare mode and raises in double compare; secondary match lowers
          if (internal_channel_counter == primary_active) begin
            case (mode)
              `OCPU_MODE_SC_SHOT_LO: begin
                pin_level <= 1'b0;
                shot_done <= 1'b1;
              end
              `OCPU_MODE_SC_SHOT_HI: begin
                pin_level <= 1'b1;
                shot_done <= 1'b1;
              end
              default: pin_level <= 1'b1; // see [R08]
            endcase
            if (!mode[2])
              compare_interrupt_flag <= 1'b1;
            if (mode == `OCPU_MODE_SC_TOGGLE)
              pin_level <= ~pin_level;
          end else if (mode[2] && internal_channel_counter == secondary_active) begin
            pin_level              <= 1'b0; // see [R08]
            compare_interrupt_flag <= 1'b1;
            if (mode == `OCPU_MODE_DC_SHOT)
              shot_done <= 1'b1;
          end
        end
      end
    end
  end

  // Fault state follows the status bit or the live input
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      fault_active <= 1'b0;
    else if (clk_en)
      fault_active <= is_pwm && (fault_in || ctrl1[`OCPU_FLTSTAT_BIT]); // see [R12] [R13]
  end

endmodule // ocpu_channel

// >>> bench/ocpu_channel_sva.sv
// Port checker for the compare/PWM channel
// Assumes a bind onto ocpu_channel; control writes use lanes 0 and 1
`timescale 1ns/1ns
module ocpu_channel_sva #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire             clk,
  input wire             nrst,
  input wire             clk_en,
  // Bus
  input wire [3:0]       address,
  input wire             read,
  input wire             write,
  input wire [31:0]      writedata,
  input wire             waitrequest,
  // Channel
  input wire [31:0]      source_event,
  input wire             fault_pin_a,
  input wire             cascade_carry_out,
  input wire             compare_output_pin,
  input wire             compare_output_oe,
  input wire [WIDTH-1:0] internal_channel_counter
);
  reg [15:0] c1;
  reg [15:0] c2;
  wire       flt;
  // Shadow copies of both control registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c1 <= 16'h0000;
      c2 <= 16'h000C;
    end else if (clk_en && write && address == 4'h0) begin
      c1 <= writedata[15:0];
    end else if (clk_en && write && address == 4'h4) begin
      c2 <= writedata[15:0];
    end
  end
  assign flt = fault_pin_a && c1[7] && c1[2:1] == 2'b11 && !c2[12];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_wr_nowait; write |-> !waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_lat; $rose(read) |-> waitrequest ##1 !waitrequest; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
  property p_tris; c2[5] |-> !compare_output_oe; endproperty
  a_tris: assert property (p_tris) else $error("pin driven while tri-stated");
  property p_flt_lvl; (flt && !c2[13]) [*6] |-> compare_output_pin == c2[14]; endproperty
  a_flt_lvl: assert property (p_flt_lvl) else $error("fault level wrong");
  property p_flt_tri; (flt && c2[13]) [*6] |-> !compare_output_oe; endproperty
  a_flt_tri: assert property (p_flt_tri) else $error("fault did not release pin");
  property p_sync;
    clk_en && !c2[7] && c2[4:0] != 5'h00 && c2[4:0] != 5'h1F && source_event[c2[4:0]]
      |=> internal_channel_counter == 0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync event did not clear counter");
  property p_carry; clk_en && cascade_carry_out |=> internal_channel_counter == 0; endproperty
  a_carry: assert property (p_carry) else $error("carry without wrap");
  property p_step;
    clk_en && $changed(internal_channel_counter) |-> internal_channel_counter == 0 ||
      internal_channel_counter == $past(internal_channel_counter) + 1'b1 ||
      internal_channel_counter == $past(internal_channel_counter) - 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("counter jumped");
endmodule // ocpu_channel_sva

// >>> bench/ocpu_load_model.sv
// Load on the compare output: pulled-down input that times the waveform
// Assumes pin and enable come straight from the channel
`timescale 1ns/1ns
module ocpu_load_model (
  // Clock
  input  wire        clk,
  // Output stage
  input  wire        pin,
  input  wire        oe,
  // Measurements
  output wire        level,
  output reg  [15:0] period,
  output reg  [15:0] high_cnt
);
  reg        last;
  reg [15:0] run;
  reg [15:0] hrun;
  // Pull-down takes the line low when released
  assign level = oe ? pin : 1'b0;
  always @(posedge clk) begin
    last <= level;
    run <= (level && !last) ? 16'h0001 : run + 16'h0001;
    hrun <= (level && !last) ? 16'h0001 : hrun + {15'h0000, level};
    if (level && !last) begin
      period <= run;
      high_cnt <= hrun;
    end
  end
endmodule // ocpu_load_model

// >>> bench/test_output_compare_pwm_unit.sv
// Testbench for the compare/PWM channel
// Assumes checker and load model compile first
`timescale 1ns/1ns
module test_output_compare_pwm_unit;
  reg         clk;
  reg         nrst;
  reg  [3:0]  address;
  reg         read;
  reg         write;
  reg  [31:0] writedata;
  reg  [4:0]  timer_tick;
  reg  [31:0] source_event;
  reg         fault_pin_a;
  reg         fault_pin_b;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        pin;
  wire        oe;
  wire [15:0] cnt;
  wire        level;
  wire [15:0] period;
  wire [15:0] high_cnt;
  integer     n_mismatch;
  integer     compares;
  reg  [31:0] rd;
  wire        irq;
  integer     irq_cnt;
  ocpu_channel dut (.clk(clk), .nrst(nrst), .clk_en(1'b1), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .timer_tick(timer_tick), .source_event(source_event),
    .cascade_carry_in(1'b0), .cascade_carry_out(), .fault_pin_a(fault_pin_a),
    .fault_pin_b(fault_pin_b), .cpu_idle(1'b0), .compare_output_pin(pin),
    .compare_output_oe(oe), .compare_interrupt_flag(irq), .internal_channel_counter(cnt));
  ocpu_load_model u_load (.clk(clk), .pin(pin), .oe(oe), .level(level), .period(period),
    .high_cnt(high_cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) timer_tick <= ~timer_tick;
  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task hang;
    begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  endtask
  task wait_ack;
    integer k;
    reg     w;
    begin
      k = 0;
      @(negedge clk);
      w = waitrequest;
      @(posedge clk);
      while (w !== 1'b0) begin
        k = k + 1;
        if (k > 50) hang;
        @(negedge clk);
        w = waitrequest;
        @(posedge clk);
      end
    end
  endtask
  task bus_wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      write <= 1'b1;
      wait_ack;
      write <= 1'b0;
    end
  endtask
  task bus_rd(input [3:0] a);
    begin
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      wait_ack;
      rd = readdata;
      read <= 1'b0;
    end
  endtask
  task wait_cnt(input [15:0] v);
    integer k;
    begin
      k = 0;
      while (cnt !== v) begin
        @(negedge clk);
        k = k + 1;
        if (k > 70000) hang;
      end
    end
  endtask
  task wait_pin(input v);
    integer k;
    begin
      k = 0;
      while (level !== v) begin
        @(negedge clk);
        k = k + 1;
        if (k > 200) hang;
      end
      @(posedge clk);
    end
  endtask
  task hold_pin(input v, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(negedge clk);
        chk({31'h0, level}, {31'h0, v});
      end
      @(posedge clk);
    end
  endtask
  task t_regs;
    begin
      bus_rd(4'h0);
      chk(rd, 32'h0000_0000);
      bus_rd(4'h4);
      chk(rd, 32'h0000_000C);
      bus_wr(4'h4, 16'hFFFF);
      bus_rd(4'h4);
      chk(rd, 32'h0000_F1FF);
      bus_rd(4'h2);
      chk(rd, 32'h0000_0000);
    end
  endtask
  task t_pwm;
    begin
      bus_wr(4'h4, 16'h001F);
      bus_wr(4'h8, 16'h0007);
      bus_wr(4'hC, 16'h0003);
      bus_wr(4'h0, 16'h1C06);
      repeat (40) @(posedge clk);
      chk({16'h0, period}, 32'd8);
      rd = {16'h0, high_cnt};
      bus_wr(4'hC, 16'h0005);
      repeat (40) @(posedge clk);
      chk({16'h0, high_cnt} - rd, 32'd2);
      bus_wr(4'h0, 16'h1C07);
      repeat (60) @(posedge clk);
      chk({16'h0, period}, 32'd16);
      bus_wr(4'h0, 16'h1C06);
      bus_wr(4'hC, 16'h0009);
      repeat (30) @(posedge clk);
      hold_pin(1'b1, 20);
      bus_wr(4'h8, 16'h0000);
      bus_wr(4'hC, 16'h0000);
      repeat (30) @(posedge clk);
      hold_pin(1'b0, 20);
    end
  endtask
  task t_fault;
    begin
      bus_wr(4'h8, 16'h0007);
      bus_wr(4'hC, 16'h0003);
      bus_wr(4'h4, 16'hC01F);
      bus_wr(4'h0, 16'h1C86);
      rd = irq_cnt;
      fault_pin_b <= 1'b1;
      wait_pin(1'b0);
      wait_pin(1'b1);
      fault_pin_a <= 1'b1;
      fault_pin_b <= 1'b0;
      repeat (8) @(posedge clk);
      fault_pin_a <= 1'b0;
      hold_pin(1'b1, 20);
      chk({31'h0, irq_cnt > rd}, 32'h1);
      bus_rd(4'h0);
      chk(rd, 32'h0000_1C96);
      bus_wr(4'h0, 16'h1C86);
      wait_pin(1'b0);
      bus_wr(4'h4, 16'h201F);
      fault_pin_a <= 1'b1;
      repeat (8) @(posedge clk);
      chk({31'h0, oe}, 32'h0);
      fault_pin_a <= 1'b0;
      bus_wr(4'h4, 16'h003F);
      @(posedge clk);
      chk({31'h0, oe}, 32'h0);
    end
  endtask
  task t_dc;
    begin
      bus_wr(4'h0, 16'h1C00);
      bus_wr(4'h8, 16'h0002);
      bus_wr(4'hC, 16'h0005);
      bus_wr(4'h4, 16'h010C);
      bus_wr(4'h0, 16'h1C05);
      source_event <= 32'h0000_1000;
      @(posedge clk);
      source_event <= 32'h0;
      wait_cnt(16'h0001);
      chk({31'h0, pin}, 32'h0);
      wait_cnt(16'h0004);
      chk({31'h0, pin}, 32'h1);
      wait_cnt(16'h0008);
      chk({31'h0, pin}, 32'h0);
      wait_cnt(16'hFFFF);
      @(negedge clk);
      chk({16'h0, cnt}, 32'h0);
      wait_cnt(16'h0004);
      chk({31'h0, pin}, 32'h1);
      bus_wr(4'h0, 16'h0005);
      @(negedge clk);
      rd = {16'h0, cnt};
      repeat (10) @(negedge clk);
      chk({16'h0, cnt} - rd, 32'd5);
    end
  endtask
  initial begin
    n_mismatch = 0;
    compares = 0;
    irq_cnt = 0;
    nrst = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    timer_tick = 5'h00;
    source_event = 32'h0;
    fault_pin_a = 1'b0;
    fault_pin_b = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_pwm;
    t_fault;
    t_dc;
    end_sim;
  end
endmodule // test_output_compare_pwm_unit
bind ocpu_channel ocpu_channel_sva #(.WIDTH(WIDTH)) u_sva (.clk(clk), .nrst(nrst), .clk_en(clk_en),
  .address(address), .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .source_event(source_event), .fault_pin_a(fault_pin_a), .cascade_carry_out(cascade_carry_out),
  .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
  .internal_channel_counter(internal_channel_counter));
